// ==== logic/sacc_pkg.sv ====
// Purpose: shared constants for the conversion control block
// Assumes: 8-bit register port, 25 MHz system clock
// Notes: status/control, result and clock registers sit at consecutive offsets
package sacc_pkg;
	// =========================================
	// register map
	localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h38;
	localparam logic [7:0] ADDR_RESULT = 8'h39;
	localparam logic [7:0] ADDR_CLOCK = 8'h3A;
	// =========================================
	// status/control field positions and reset
	localparam int DONE_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	localparam int CONT_BIT = 5;
	localparam logic [4:0] CHANNEL_OFF = 5'h1F;
	localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1F;
	// =========================================
	// clock register field positions and reset
	localparam int PRESCALE_LSB = 5;
	localparam int CLKSEL_BIT = 4;
	localparam logic [2:0] PRESCALE_RESET = 3'h0;
	localparam logic CLKSEL_RESET = 1'b0;
	// =========================================
	// channels and conversion timing
	localparam int NUM_CHANNELS = 15;
	localparam logic [3:0] CONV_LAST_TICK = 4'hF;
	localparam logic [3:0] SAMPLE_TICK = 4'h0;
	localparam logic [3:0] LAST_BIT_TICK = 4'h8;
	localparam int CLK_PERIOD_NS = 40;
endpackage

// ==== logic/sacc_sar.sv ====
// Purpose: successive-approximation sequencer of the conversion control block
// Assumes: tick is one-cycle pulse at the internal converter clock rate
// Notes: one sampling tick, eight bit ticks, then idle ticks up to sixteen
`timescale 1ns/1ps
module sacc_sar (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic start,
	input wire logic abort,
	input wire logic tick,
	// analog comparator, high when the input is at or above trial_code
	input wire logic comp_in,
	// results
	output logic busy,
	output logic done,
	output logic sampling,
	output logic [7:0] trial_code,
	output logic [7:0] result
);
	// =========================================
	// state
	typedef struct packed {
		logic busy;
		logic done;
		logic [3:0] cnt;
		logic [7:0] code;
		logic [7:0] result;
	} sacc_sar_state_t;

	sacc_sar_state_t st;
	sacc_sar_state_t next_st;

	// =========================================
	// sequencer
	always_comb begin
		logic [2:0] b;
		b = 3'(4'h8 - st.cnt);
		next_st = st;
		next_st.done = 1'b0;
		if (abort) begin
			next_st.busy = 1'b0;
		end else if (start) begin
			next_st.busy = 1'b1;
			next_st.cnt = 4'h0;
			next_st.code = 8'h00;
		end else if (st.busy && tick) begin
			next_st.cnt = st.cnt + 4'h1;
			if (st.cnt == sacc_pkg::SAMPLE_TICK) begin
				next_st.code = 8'h80;
			end else if (st.cnt <= sacc_pkg::LAST_BIT_TICK) begin
				// msb first: keep or drop the trial bit, then try the next one
				if (!comp_in) begin
					next_st.code[b] = 1'b0;
				end
				if (b != 3'h0) begin
					next_st.code[b - 3'h1] = 1'b1;
				end
			end
			if (st.cnt == sacc_pkg::CONV_LAST_TICK) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.result = st.code;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
	assign done = st.done;
	assign sampling = st.busy && (st.cnt == sacc_pkg::SAMPLE_TICK);
	assign trial_code = st.code;
	assign result = st.result;
endmodule

// ==== logic/sacc_top.sv ====
// Purpose: register file, clocking, mode control and pin override for an 8-bit converter
// Assumes: register port on the system clock, comparator and port logic outside
// Notes: a conversion takes 16 internal converter ticks after the start write
//
// Overview of operation
// - channel field routes one of fifteen inputs
// - completion stores result, then flag or interrupt
// - selected channel pin forced to converter input
// - unselected pins stay normal general-purpose pins
// - port writes cannot touch claimed pin
// - claimed pin reads zero or output latch
// - full scale code at reference, zero at ground
// - control write starts; sixteen to seventeen ticks, here always sixteen ticks
// - continuous results overwrite unread result
// - continuous conversions repeat until bit cleared
// - flag stays set until write or read
// - enabled interrupt raised after every conversion
// - with interrupts on, flag is not completion
// - wait mode runs normally, interrupt wakes
// - stop mode aborts conversion without result
// - conversions resume after stop, allow settling
// - result read or control write clears interrupt
// - all-ones channel field powers off, reset value
// - prescaler divides by 1,2,4,8, else 16
// - clock select: bus when 1, crystal reset
`timescale 1ns/1ps
module sacc_top #(
	parameter int NCH = sacc_pkg::NUM_CHANNELS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rd_data,
	// system
	input wire logic crystal_clock,
	input wire logic stop_mode,
	input wire logic wait_mode,
	output logic irq_request,
	// analog side
	input wire logic comp_in,
	output logic [4:0] mux_select,
	output logic analog_power_on,
	output logic sampling,
	output logic [7:0] trial_code,
	// shared port pins
	input wire logic [NCH-1:0] port_latch,
	input wire logic [NCH-1:0] port_dir,
	input wire logic [NCH-1:0] pin_in,
	output logic [NCH-1:0] pin_out,
	output logic [NCH-1:0] pin_oe_n,
	output logic [NCH-1:0] pin_claimed,
	output logic [NCH-1:0] port_read_value
);
	initial begin
		if (NCH < 1 || NCH > 15) begin
			$error("sacc_top: channel count must be 1 to 15");
		end
	end

	// =========================================
	// helpers
	function automatic logic [4:0] prescale_div(input logic [2:0] code);
		if (code[2]) begin
			prescale_div = 5'h10;
		end else begin
			prescale_div = 5'(5'h01 << code[1:0]);
		end
	endfunction

	function automatic logic [NCH-1:0] claim_of(input logic [4:0] ch);
		logic [NCH-1:0] m;
		m = '0;
		for (int i = 0; i < NCH; i++) begin
			if (ch == 5'(i)) begin
				m[i] = 1'b1;
			end
		end
		claim_of = m;
	endfunction

	// =========================================
	// state
	typedef struct packed {
		logic done_flag;
		logic irq_enable;
		logic continuous_bit;
		logic [4:0] channel_select;
		logic [2:0] clock_prescale;
		logic conv_clock_select;
		logic irq_pend;
		logic [2:0] xtal_sync;
		logic [4:0] div_cnt;
		logic [NCH-1:0] pin_s1;
		logic [NCH-1:0] pin_s2;
		logic [NCH-1:0] pin_s3;
		logic [NCH-1:0] pin_val;
		logic [NCH-1:0] read_val;
		logic [7:0] rd_data;
	} sacc_state_t;

	sacc_state_t st;
	sacc_state_t next_st;

	logic wr_ctl;
	logic rd_result;
	logic powered;
	logic new_on;
	logic src_edge;
	logic tick;
	logic start;
	logic abort;
	logic busy;
	logic done;
	logic [7:0] result;
	logic [NCH-1:0] claim;

	assign wr_ctl = wr && (addr == sacc_pkg::ADDR_STATUS_CONTROL);
	assign rd_result = rd && (addr == sacc_pkg::ADDR_RESULT);
	assign powered = (st.channel_select != sacc_pkg::CHANNEL_OFF);
	assign claim = claim_of(st.channel_select);
	// crystal edge counts when the second stage is high and the third stage is still low
	assign src_edge = st.conv_clock_select ? 1'b1 : (st.xtal_sync[1] && !st.xtal_sync[2]);
	assign tick = src_edge && (st.div_cnt == 5'(prescale_div(st.clock_prescale) - 5'h01));
	// wait mode does not gate anything: the converter keeps running
	// a control write is judged by the channel it writes, not the one it replaces
	assign new_on = (wr_data[4:0] != sacc_pkg::CHANNEL_OFF);
	assign abort = stop_mode || (wr_ctl ? !new_on : !powered);
	assign start = !abort && !busy && (wr_ctl || st.continuous_bit);

	// =========================================
	// sequencer
	sacc_sar u_sar (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(start),
		.abort(abort),
		.tick(tick),
		.comp_in(comp_in),
		.busy(busy),
		.done(done),
		.sampling(sampling),
		.trial_code(trial_code),
		.result(result)
	);

	// =========================================
	// registers and control
	always_comb begin
		next_st = st;
		// crystal clock and pin synchronisers
		next_st.xtal_sync = {st.xtal_sync[1:0], crystal_clock};
		next_st.pin_s1 = pin_in;
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_s3 = st.pin_s2;
		for (int i = 0; i < NCH; i++) begin
			if (st.pin_s2[i] == st.pin_s3[i]) begin
				next_st.pin_val[i] = st.pin_s3[i];
			end
		end
		// prescaler restarts with every conversion so ticks line up with start
		if (start) begin
			next_st.div_cnt = 5'h00;
		end else if (tick) begin
			next_st.div_cnt = 5'h00;
		end else if (src_edge) begin
			next_st.div_cnt = st.div_cnt + 5'h01;
		end
		// claimed pin reads zero or the latch, others read the latch or the pin
		for (int i = 0; i < NCH; i++) begin
			if (claim[i]) begin
				next_st.read_val[i] = port_dir[i] ? port_latch[i] : 1'b0;
			end else begin
				next_st.read_val[i] = port_dir[i] ? port_latch[i] : st.pin_val[i];
			end
		end
		// register writes; flags clear here and set below so a set wins
		if (wr_ctl) begin
			next_st.irq_enable = wr_data[sacc_pkg::IRQ_EN_BIT];
			next_st.continuous_bit = wr_data[sacc_pkg::CONT_BIT];
			next_st.channel_select = wr_data[4:0];
			// done flag is software-owned only while interrupts are enabled
			next_st.done_flag = wr_data[sacc_pkg::IRQ_EN_BIT] ? wr_data[sacc_pkg::DONE_BIT] : 1'b0;
			next_st.irq_pend = 1'b0;
		end
		if (wr && addr == sacc_pkg::ADDR_CLOCK) begin
			next_st.clock_prescale = wr_data[sacc_pkg::PRESCALE_LSB +: 3];
			next_st.conv_clock_select = wr_data[sacc_pkg::CLKSEL_BIT];
		end
		if (rd_result) begin
			next_st.irq_pend = 1'b0;
			if (!st.irq_enable) begin
				next_st.done_flag = 1'b0;
			end
		end
		// completion: result already stored by the sequencer
		if (done) begin
			if (st.irq_enable) begin
				next_st.irq_pend = 1'b1;
			end else begin
				next_st.done_flag = 1'b1;
			end
		end
		// read data, valid in the cycle after the strobe
		next_st.rd_data = 8'h00;
		if (rd) begin
			unique case (addr)
				sacc_pkg::ADDR_STATUS_CONTROL: begin
					next_st.rd_data = {st.done_flag, st.irq_enable, st.continuous_bit, st.channel_select};
				end
				sacc_pkg::ADDR_RESULT: begin
					next_st.rd_data = result;
				end
				sacc_pkg::ADDR_CLOCK: begin
					next_st.rd_data = {st.clock_prescale, st.conv_clock_select, 4'h0};
				end
				default: begin
					next_st.rd_data = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.channel_select <= sacc_pkg::CHANNEL_OFF;
			st.clock_prescale <= sacc_pkg::PRESCALE_RESET;
			st.conv_clock_select <= sacc_pkg::CLKSEL_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// =========================================
	// outputs
	assign rd_data = st.rd_data;
	assign irq_request = st.irq_pend && st.irq_enable;
	assign mux_select = st.channel_select;
	assign analog_power_on = powered && !stop_mode;
	assign pin_claimed = claim;
	assign pin_out = port_latch;
	// a claimed pin is never driven whatever the port registers hold
	assign pin_oe_n = ~(port_dir & ~claim);
	assign port_read_value = st.read_val;
endmodule

// ==== tb/sacc_ana_model.sv ====
// Purpose: comparator model behind the channel multiplexer
// Assumes: level holds each channel's input in codes
// Notes: power-off and unused selects read low
`timescale 1ns/1ps
module sacc_ana_model (
	// analog side
	input wire logic [4:0] mux_select,
	input wire logic [7:0] trial_code,
	input wire logic [7:0] level [15],
	output logic comp_in
);
	// ==========
	// comparator
	assign comp_in = (mux_select < 5'h0F) ? (level[mux_select] >= trial_code) : 1'b0;
endmodule

// ==== tb/sacc_chk.sv ====
// Purpose: port assertions for the conversion control block
// Assumes: ce held high by the bench
// Notes: bound to every sacc_top instance
`timescale 1ns/1ps
module sacc_chk #(
	parameter int NCH = 15
) (
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic rd,
	input wire logic [7:0] rd_data,
	input wire logic stop_mode,
	input wire logic irq_request,
	input wire logic [4:0] mux_select,
	input wire logic analog_power_on,
	input wire logic sampling,
	input wire logic [NCH-1:0] port_latch,
	input wire logic [NCH-1:0] port_dir,
	input wire logic [NCH-1:0] pin_out,
	input wire logic [NCH-1:0] pin_oe_n,
	input wire logic [NCH-1:0] pin_claimed,
	input wire logic [NCH-1:0] port_read_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========
	// assertions
	rd_idle_a: assert property (!$past(rd) |-> rd_data == 8'h00) else $error("read data outside read slot");
	power_gate_a: assert property (analog_power_on == (mux_select != 5'h1F && !stop_mode))
		else $error("power state wrong");
	stop_abort_a: assert property (stop_mode |=> !sampling) else $error("sampling in stop");
	claim_sel_a: assert property (pin_claimed == ((mux_select < NCH) ? (NCH'(1) << mux_select) : '0))
		else $error("claimed pin wrong");
	claim_oe_a: assert property (pin_oe_n == ~(port_dir & ~pin_claimed))
		else $error("claimed pin driven");
	claim_read_a: assert property (|$past(pin_claimed) |-> (port_read_value & $past(pin_claimed)) ==
		($past(port_latch) & $past(port_dir) & $past(pin_claimed))) else $error("claimed pin read wrong");
	pin_pass_a: assert property (pin_out == port_latch) else $error("port output wrong");
	irq_clear_a: assert property (rd && addr == 8'h39 |=> !irq_request) else $error("irq not cleared");
	cover property ($rose(sampling));
	cover property ($rose(irq_request));
	cover property (|(pin_claimed & ~port_dir));
endmodule
bind sacc_top sacc_chk #(.NCH(NCH)) chk_u (.clk, .rst, .addr, .rd, .rd_data, .stop_mode, .irq_request, .mux_select,
	.analog_power_on, .sampling, .port_latch, .port_dir, .pin_out, .pin_oe_n, .pin_claimed, .port_read_value);

// ==== tb/sacc_top_tb.sv ====
// Purpose: register-level bench of the conversion control block
// Assumes: bus clock source for timed conversions
// Notes: one read per slot, checks made at falling edges
`timescale 1ns/1ps
module sacc_top_tb;
	logic clk, rst, ce, wr, rd, crystal_clock, stop_mode, wait_mode, comp_in, irq_request, analog_power_on, sampling;
	logic [7:0] addr, wr_data, rd_data, trial_code;
	logic [4:0] mux_select;
	logic [14:0] port_latch, port_dir, pin_in, pin_out, pin_oe_n, pin_claimed, port_read_value;
	logic [7:0] lv [15];
	int n_mismatch, checked;
	sacc_top dut_u (.clk, .rst, .ce, .addr, .wr_data, .wr, .rd, .rd_data, .crystal_clock, .stop_mode, .wait_mode,
		.irq_request, .comp_in, .mux_select, .analog_power_on, .sampling, .trial_code, .port_latch, .port_dir,
		.pin_in, .pin_out, .pin_oe_n, .pin_claimed, .port_read_value);
	sacc_ana_model ana_u (.mux_select, .trial_code, .level(lv), .comp_in);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		crystal_clock = 1'b0;
		forever #70 crystal_clock = ~crystal_clock;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
	// ==========
	// tasks
	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk({8'h00, rd_data}, {8'h00, exp});
	endtask
	task automatic conv(input logic [7:0] ctl, input int d);
		logic [14:0] cl;
		cl = (ctl[4:0] < 5'h0F) ? (15'h0001 << ctl[4:0]) : 15'h0000;
		wr_reg(8'h38, ctl);
		repeat (16 * d - 3) @(posedge clk);
		@(negedge clk);
		chk({1'b0, pin_claimed}, {1'b0, cl});
		chk({1'b0, pin_oe_n}, {1'b0, ~(port_dir & ~cl)});
		chk({1'b0, port_read_value}, {1'b0, (port_latch & port_dir) | (pin_in & ~port_dir & ~cl)});
		rd_chk(8'h38, {1'b0, ctl[6:0]});
		repeat (d + 4) @(posedge clk);
		@(negedge clk);
		chk({15'h0000, irq_request}, {15'h0000, ctl[6]});
		rd_chk(8'h38, {~ctl[6], ctl[6:0]});
		rd_chk(8'h39, lv[ctl[3:0]]);
		chk({15'h0000, irq_request}, 16'h0000);
		rd_chk(8'h38, {1'b0, ctl[6:0]});
	endtask
	// ==========
	// sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
		stop_mode = 1'b0;
		wait_mode = 1'b0;
		port_latch = 15'h2AAA;
		port_dir = 15'h00FF;
		pin_in = 15'h7F00;
		for (int i = 0; i < 15; i++) begin
			lv[i] = 8'(i * 18);
		end
		lv[14] = 8'hFF;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h38, 8'h1F);
		rd_chk(8'h3A, 8'h00);
		rd_chk(8'h50, 8'h00);
		wr_reg(8'h39, 8'h77);
		wr_reg(8'h3A, 8'h10);
		rd_chk(8'h3A, 8'h10);
		conv(8'h00, 1);
		conv(8'h0E, 1);
		conv(8'h09, 1);
		wait_mode <= 1'b1;
		conv(8'h43, 1);
		wait_mode <= 1'b0;
		for (int k = 1; k < 5; k++) begin
			wr_reg(8'h3A, {3'(k), 5'h10});
			conv(8'h05, 1 << k);
		end
		wr_reg(8'h3A, 8'h10);
		lv[2] = 8'h10;
		wr_reg(8'h38, 8'h22);
		repeat (20) @(posedge clk);
		lv[2] <= 8'h20;
		repeat (40) @(posedge clk);
		rd_chk(8'h39, 8'h20);
		repeat (20) @(posedge clk);
		rd_chk(8'h38, 8'hA2);
		wr_reg(8'h38, 8'h1F);
		wr_reg(8'h38, 8'h04);
		repeat (5) @(posedge clk);
		stop_mode <= 1'b1;
		repeat (30) @(posedge clk);
		stop_mode <= 1'b0;
		rd_chk(8'h38, 8'h04);
		conv(8'h06, 1);
		give_verdict();
	end
endmodule
